//--- rtl/hs_serdes_config_regs.sv
// Line-side serdes configuration registers with Wishbone slave
// What this block does
// - Decode PLL multiplier code to factor; 0000, 0001, 1111 reserved.
// - Swing code lives in bits 15:12 of register two, resets 1000.
// - Swing codes map monotonically to sixteen amplitudes, 130 to 1400 mV.
// - Bit 11 enables the transmitter, resets to one.
// - Transmitter forced off by low power-down pin or global power-down.
// - Bit 10 freezes the receive equalizer when set, resets zero.
// - Hold, track and cursor fields follow training unless overridden.
// - Transmit rate bits 9:8 select full, half, quarter, eighth.
// - Rates and multiplier automatic unless frequency select or override.
// - Receive rate 000, 101, 110, 111 valid; other codes reserved.
// - Bit 3 receiver enable, auto unless overridden, off at power-down.
// - Bit 15 of register three forces ADC track mode.
// - Bits 14:12 pick precursor ninths; 111 disables, resets 001.
// - Bits 11:10 pick recovery loop order; 11 reserved, resets 10.
// - Bits 9:8 pick four to thirty-two vote threshold, resets 00.
// - Bit 6 turns off high-frequency peaking, for slow links.
// - Bit 5 selects short-channel clock recovery mode.
// - Cursor reduction code in bits 4:0 of register three, resets zero.
// - Cursor codes map to percent; 00111 to 01111 reserved.
// - Register two at index 3, resets 0x8848, reserved bits kept.
// - Multiplier code in bits 3:0 of register one, resets 1101.
`timescale 1ns/1ps
`default_nettype none
module hs_serdes_config_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic channel_powerdown_n_i,
    input wire logic ref_frequency_select_one_i,
    input wire logic lt_eq_hold_i,
    input wire logic lt_adc_track_i,
    input wire logic [4:0] lt_cursor_reduction_i,
    input wire logic [1:0] auto_tx_rate_i,
    input wire logic [2:0] auto_rx_rate_i,
    input wire logic [3:0] auto_pll_multiplier_i,
    input wire logic auto_rx_enable_i,
    output logic [3:0] tx_swing_code_o,
    output logic [10:0] tx_amplitude_mv_o,
    output logic tx_enable_o,
    output logic rx_enable_o,
    output logic eq_hold_o,
    output logic [1:0] tx_rate_sel_o,
    output logic [2:0] rx_rate_sel_o,
    output logic [1:0] rx_rate_shift_o,
    output logic rx_rate_reserved_o,
    output logic [3:0] pll_multiplier_sel_o,
    output logic [6:0] pll_mult_x4_o,
    output logic pll_mult_valid_o,
    output logic adc_track_force_o,
    output logic rx_precursor_en_o,
    output logic [3:0] rx_precursor_ninths_o,
    output logic [1:0] cdr_loop_order_sel_o,
    output logic cdr_order_reserved_o,
    output logic [5:0] cdr_vote_count_o,
    output logic hf_peaking_off_o,
    output logic short_channel_cdr_o,
    output logic [4:0] cursor_reduction_sel_o,
    output logic [9:0] cursor_reduction_tenths_o,
    output logic cursor_reduction_valid_o
);

    typedef struct packed {
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [15:0] ctrl3;
        logic [7:0] ovr;
        logic pd_s1;
        logic pd_s2;
        logic rf_s1;
        logic rf_s2;
        logic ack;
        logic [31:0] dat;
        logic [3:0] swing;
        logic [10:0] amp;
        logic tx_en;
        logic rx_en;
        logic eq_hold;
        logic [1:0] tx_rate;
        logic [2:0] rx_rate;
        logic [1:0] rx_shift;
        logic rx_rsv;
        logic [3:0] pll;
        logic [6:0] pll_x4;
        logic pll_ok;
        logic track;
        logic pre_en;
        logic [3:0] pre_num;
        logic [1:0] order;
        logic order_rsv;
        logic [5:0] votes;
        logic peak_off;
        logic short_cdr;
        logic [4:0] crf;
        logic [9:0] crf_tenths;
        logic crf_ok;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // Typical amplitude in mV for each swing code
    function automatic logic [10:0] swing_mv(input logic [3:0] c);
        logic [10:0] r;
        r = 11'h000;
        case (c)
            4'h0: r = 11'h082;
            4'h1: r = 11'h0dc;
            4'h2: r = 11'h12c;
            4'h3: r = 11'h186;
            4'h4: r = 11'h1e0;
            4'h5: r = 11'h23a;
            4'h6: r = 11'h294;
            4'h7: r = 11'h2ee;
            4'h8: r = 11'h33e;
            4'h9: r = 11'h3a2;
            4'ha: r = 11'h3fc;
            4'hb: r = 11'h456;
            4'hc: r = 11'h49c;
            4'hd: r = 11'h4f6;
            4'he: r = 11'h53c;
            default: r = 11'h578;
        endcase
        return r;
    endfunction

    // Multiplier factor times four; zero marks a reserved code
    function automatic logic [6:0] mult_x4(input logic [3:0] c);
        logic [6:0] r;
        r = 7'h00;
        case (c)
            4'h2: r = 7'h10;
            4'h3: r = 7'h14;
            4'h4: r = 7'h18;
            4'h5: r = 7'h20;
            4'h6: r = 7'h21;
            4'h7: r = 7'h28;
            4'h8: r = 7'h30;
            4'h9: r = 7'h32;
            4'ha: r = 7'h3c;
            4'hb: r = 7'h40;
            4'hc: r = 7'h42;
            4'hd: r = 7'h50;
            4'he: r = 7'h64;
            default: r = 7'h00;
        endcase
        return r;
    endfunction

    // Cursor reduction in tenths of a percent
    function automatic logic [9:0] crf_pct(input logic [4:0] c);
        logic [9:0] r;
        r = 10'h000;
        case (c)
            5'h01: r = 10'h019;
            5'h02: r = 10'h032;
            5'h03: r = 10'h04b;
            5'h04: r = 10'h064;
            5'h05: r = 10'h078;
            5'h06: r = 10'h096;
            5'h10: r = 10'h0aa;
            5'h11: r = 10'h0c8;
            5'h12: r = 10'h0dc;
            5'h13: r = 10'h0fa;
            5'h14: r = 10'h10e;
            5'h15: r = 10'h12c;
            5'h16: r = 10'h140;
            5'h17: r = 10'h15e;
            5'h18: r = 10'h172;
            5'h19: r = 10'h190;
            5'h1a: r = 10'h1a4;
            5'h1b: r = 10'h1c2;
            5'h1c: r = 10'h1d6;
            5'h1d: r = 10'h1f4;
            5'h1e: r = 10'h208;
            5'h1f: r = 10'h226;
            default: r = 10'h000;
        endcase
        return r;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    logic [5:0] idx;
    logic req;
    logic wr;
    logic use_reg;
    logic pd_off;
    logic [1:0] txr;
    logic [2:0] rxr;
    logic [3:0] pllc;
    logic [4:0] crfc;
    logic [15:0] stat;
    logic [15:0] rd;

    always_comb begin
        nxt_st = st_ff;
        idx = wb_adr_i[7:2];
        req = wb_cyc_i & wb_stb_i;
        wr = req & wb_we_i & st_ff.ack;
        use_reg = st_ff.rf_s2 | st_ff.ovr[serdes_cfg_pkg::OVR_RATE_BIT];
        pd_off = ~st_ff.pd_s2 | st_ff.ovr[serdes_cfg_pkg::GLOBAL_PD_BIT];
        stat = {8'h00, st_ff.crf_ok, st_ff.order_rsv, st_ff.rx_rsv,
                st_ff.pll_ok, st_ff.track, st_ff.eq_hold, st_ff.rx_en,
                st_ff.tx_en};
        rd = 16'h0000;
        // Unmapped addresses read as zero and are still acknowledged
        if (idx == serdes_cfg_pkg::IDX_CTRL1) begin
            rd = st_ff.ctrl1;
        end else if (idx == serdes_cfg_pkg::IDX_CTRL2) begin
            rd = st_ff.ctrl2;
        end else if (idx == serdes_cfg_pkg::IDX_CTRL3) begin
            rd = st_ff.ctrl3;
        end else if (idx == serdes_cfg_pkg::IDX_OVR) begin
            rd = {8'h00, st_ff.ovr};
        end else if (idx == serdes_cfg_pkg::IDX_STAT) begin
            rd = stat;
        end

        // Pins cross in through two flops; only the second is read
        nxt_st.pd_s1 = channel_powerdown_n_i;
        nxt_st.pd_s2 = st_ff.pd_s1;
        nxt_st.rf_s1 = ref_frequency_select_one_i;
        nxt_st.rf_s2 = st_ff.rf_s1;

        // One-cycle ack, dropped in the cycle after it was given
        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack) begin
            nxt_st.dat = {16'h0000, rd};
        end

        // Write lands on the edge where ack is seen high
        if (wr) begin
            if (idx == serdes_cfg_pkg::IDX_CTRL1) begin
                nxt_st.ctrl1 = merge16(st_ff.ctrl1, wb_dat_i,
                                       wb_sel_i);
            end else if (idx == serdes_cfg_pkg::IDX_CTRL2) begin
                // Reserved bits are stored as written
                nxt_st.ctrl2 = merge16(st_ff.ctrl2, wb_dat_i, wb_sel_i);
            end else if (idx == serdes_cfg_pkg::IDX_CTRL3) begin
                nxt_st.ctrl3 = merge16(st_ff.ctrl3, wb_dat_i,
                                       wb_sel_i);
            end else if (idx == serdes_cfg_pkg::IDX_OVR) begin
                if (wb_sel_i[0]) begin
                    nxt_st.ovr = wb_dat_i[7:0];
                end
            end
        end

        // Transmit side
        nxt_st.swing = st_ff.ctrl2[serdes_cfg_pkg::SWING_HI:
                                   serdes_cfg_pkg::SWING_LO];
        nxt_st.amp = swing_mv(nxt_st.swing);
        nxt_st.tx_en = st_ff.ctrl2[serdes_cfg_pkg::TXEN_BIT]
                       & ~pd_off;

        // Rate and multiplier selection
        if (use_reg) begin
            txr = st_ff.ctrl2[serdes_cfg_pkg::TXRATE_HI:
                              serdes_cfg_pkg::TXRATE_LO];
            rxr = st_ff.ctrl2[serdes_cfg_pkg::RXRATE_HI:
                              serdes_cfg_pkg::RXRATE_LO];
            pllc = st_ff.ctrl1[serdes_cfg_pkg::PLL_HI:
                               serdes_cfg_pkg::PLL_LO];
        end else begin
            txr = auto_tx_rate_i;
            rxr = auto_rx_rate_i;
            pllc = auto_pll_multiplier_i;
        end
        nxt_st.tx_rate = txr;
        nxt_st.rx_rate = rxr;
        nxt_st.pll = pllc;
        nxt_st.pll_x4 = mult_x4(pllc);
        nxt_st.pll_ok = (mult_x4(pllc) != 7'h00);

        // Reserved receive rates fall back to full rate and are flagged
        nxt_st.rx_rsv = 1'b0;
        case (rxr)
            serdes_cfg_pkg::RXRATE_FULL: nxt_st.rx_shift = 2'h0;
            serdes_cfg_pkg::RXRATE_HALF: nxt_st.rx_shift = 2'h1;
            serdes_cfg_pkg::RXRATE_QUARTER: nxt_st.rx_shift = 2'h2;
            serdes_cfg_pkg::RXRATE_EIGHTH: nxt_st.rx_shift = 2'h3;
            default: begin
                nxt_st.rx_shift = 2'h0;
                nxt_st.rx_rsv = 1'b1;
            end
        endcase

        // Receiver enable
        if (st_ff.ovr[serdes_cfg_pkg::OVR_RXEN_BIT]) begin
            nxt_st.rx_en = st_ff.ctrl2[serdes_cfg_pkg::RXEN_BIT] & ~pd_off;
        end else begin
            nxt_st.rx_en = auto_rx_enable_i & ~pd_off;
        end

        // Training-driven fields take software values only on override
        if (st_ff.ovr[serdes_cfg_pkg::OVR_EQ_BIT]) begin
            nxt_st.eq_hold = st_ff.ctrl2[serdes_cfg_pkg::EQHOLD_BIT];
        end else begin
            nxt_st.eq_hold = lt_eq_hold_i;
        end
        if (st_ff.ovr[serdes_cfg_pkg::OVR_TRACK_BIT]) begin
            nxt_st.track = st_ff.ctrl3[serdes_cfg_pkg::TRACK_BIT];
        end else begin
            nxt_st.track = lt_adc_track_i;
        end
        if (st_ff.ovr[serdes_cfg_pkg::OVR_CRF_BIT]) begin
            crfc = st_ff.ctrl3[serdes_cfg_pkg::CRF_HI:
                               serdes_cfg_pkg::CRF_LO];
        end else begin
            crfc = lt_cursor_reduction_i;
        end
        nxt_st.crf = crfc;
        nxt_st.crf_tenths = crf_pct(crfc);
        // Reserved codes are the 00111..01111 gap
        nxt_st.crf_ok = crfc[4] | (crfc < 5'h07);

        // Receive equalizer and clock recovery
        nxt_st.pre_en = st_ff.ctrl3[serdes_cfg_pkg::PRE_HI:
                                    serdes_cfg_pkg::PRE_LO]
                        != serdes_cfg_pkg::PRE_OFF;
        nxt_st.pre_num = {st_ff.ctrl3[serdes_cfg_pkg::PRE_HI:
                                      serdes_cfg_pkg::PRE_LO],
                          1'b1};
        nxt_st.order = st_ff.ctrl3[serdes_cfg_pkg::ORDER_HI:
                                   serdes_cfg_pkg::ORDER_LO];
        nxt_st.order_rsv = nxt_st.order == serdes_cfg_pkg::ORDER_RSV;
        nxt_st.votes = serdes_cfg_pkg::VOTE_BASE
                       << st_ff.ctrl3[serdes_cfg_pkg::VOTE_HI:
                                      serdes_cfg_pkg::VOTE_LO];
        nxt_st.peak_off = st_ff.ctrl3[serdes_cfg_pkg::PEAK_BIT];
        nxt_st.short_cdr = st_ff.ctrl3[serdes_cfg_pkg::SHORT_BIT];

        // Synchronous reset: registers to defaults, decoded outputs low
        if (rst_i) begin
            nxt_st = '0;
            nxt_st.ctrl1 = serdes_cfg_pkg::CTRL1_RST;
            nxt_st.ctrl2 = serdes_cfg_pkg::CTRL2_RST;
            nxt_st.ctrl3 = serdes_cfg_pkg::CTRL3_RST;
            nxt_st.ovr = serdes_cfg_pkg::OVR_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign tx_swing_code_o = st_ff.swing;
    assign tx_amplitude_mv_o = st_ff.amp;
    assign tx_enable_o = st_ff.tx_en;
    assign rx_enable_o = st_ff.rx_en;
    assign eq_hold_o = st_ff.eq_hold;
    assign tx_rate_sel_o = st_ff.tx_rate;
    assign rx_rate_sel_o = st_ff.rx_rate;
    assign rx_rate_shift_o = st_ff.rx_shift;
    assign rx_rate_reserved_o = st_ff.rx_rsv;
    assign pll_multiplier_sel_o = st_ff.pll;
    assign pll_mult_x4_o = st_ff.pll_x4;
    assign pll_mult_valid_o = st_ff.pll_ok;
    assign adc_track_force_o = st_ff.track;
    assign rx_precursor_en_o = st_ff.pre_en;
    assign rx_precursor_ninths_o = st_ff.pre_num;
    assign cdr_loop_order_sel_o = st_ff.order;
    assign cdr_order_reserved_o = st_ff.order_rsv;
    assign cdr_vote_count_o = st_ff.votes;
    assign hf_peaking_off_o = st_ff.peak_off;
    assign short_channel_cdr_o = st_ff.short_cdr;
    assign cursor_reduction_sel_o = st_ff.crf;
    assign cursor_reduction_tenths_o = st_ff.crf_tenths;
    assign cursor_reduction_valid_o = st_ff.crf_ok;

endmodule
`default_nettype wire

//--- rtl/serdes_cfg_pkg.sv
// Constants for the line-side serdes configuration register bank
package serdes_cfg_pkg;
    // Management device that holds these registers (informational)
    localparam logic [4:0] MGMT_DEVICE = 5'h1e;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL1 = 6'h02;
    localparam logic [5:0] IDX_CTRL2 = 6'h03;
    localparam logic [5:0] IDX_CTRL3 = 6'h04;
    localparam logic [5:0] IDX_OVR = 6'h10;
    localparam logic [5:0] IDX_STAT = 6'h11;
    // Reset values
    localparam logic [15:0] CTRL1_RST = 16'h811d;
    localparam logic [15:0] CTRL2_RST = 16'h8848;
    localparam logic [15:0] CTRL3_RST = 16'h1800;
    localparam logic [7:0] OVR_RST = 8'h00;
    // Control register one
    localparam int PLL_HI = 3;
    localparam int PLL_LO = 0;
    // Control register two
    localparam int SWING_HI = 15;
    localparam int SWING_LO = 12;
    localparam int TXEN_BIT = 11;
    localparam int EQHOLD_BIT = 10;
    localparam int TXRATE_HI = 9;
    localparam int TXRATE_LO = 8;
    localparam int RXEN_BIT = 3;
    localparam int RXRATE_HI = 2;
    localparam int RXRATE_LO = 0;
    // Control register three
    localparam int TRACK_BIT = 15;
    localparam int PRE_HI = 14;
    localparam int PRE_LO = 12;
    localparam int ORDER_HI = 11;
    localparam int ORDER_LO = 10;
    localparam int VOTE_HI = 9;
    localparam int VOTE_LO = 8;
    localparam int PEAK_BIT = 6;
    localparam int SHORT_BIT = 5;
    localparam int CRF_HI = 4;
    localparam int CRF_LO = 0;
    // Override register
    localparam int OVR_EQ_BIT = 0;
    localparam int OVR_TRACK_BIT = 1;
    localparam int OVR_CRF_BIT = 2;
    localparam int OVR_RATE_BIT = 3;
    localparam int OVR_RXEN_BIT = 4;
    localparam int GLOBAL_PD_BIT = 5;
    // Special codes
    localparam logic [2:0] PRE_OFF = 3'h7;
    localparam logic [1:0] ORDER_RSV = 2'h3;
    localparam logic [5:0] VOTE_BASE = 6'h04;
    localparam logic [2:0] RXRATE_FULL = 3'h0;
    localparam logic [2:0] RXRATE_HALF = 3'h5;
    localparam logic [2:0] RXRATE_QUARTER = 3'h6;
    localparam logic [2:0] RXRATE_EIGHTH = 3'h7;
endpackage

//--- test/hs_serdes_config_regs_sva.sv
// Port assertions for the serdes configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hs_serdes_config_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic channel_powerdown_n_i,
    input wire logic lt_eq_hold_i,
    input wire logic tx_enable_o,
    input wire logic rx_enable_o,
    input wire logic eq_hold_o,
    input wire logic [3:0] tx_swing_code_o,
    input wire logic [10:0] tx_amplitude_mv_o,
    input wire logic [3:0] pll_multiplier_sel_o,
    input wire logic [6:0] pll_mult_x4_o,
    input wire logic pll_mult_valid_o,
    input wire logic [2:0] rx_rate_sel_o,
    input wire logic rx_rate_reserved_o,
    input wire logic [1:0] cdr_loop_order_sel_o,
    input wire logic cdr_order_reserved_o,
    input wire logic [4:0] cursor_reduction_sel_o,
    input wire logic cursor_reduction_valid_o
);
    localparam int AMP [16] = '{130, 220, 300, 390, 480, 570, 660, 750,
        830, 930, 1020, 1110, 1180, 1270, 1340, 1400};
    localparam int X4 [16] = '{0, 0, 16, 20, 24, 32, 33, 40, 48, 50, 60,
        64, 66, 80, 100, 0};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pd_low;
        !channel_powerdown_n_i [*3];
    endsequence
    // Decoded outputs still hold reset zeros one edge after release
    sequence s_run;
        !$past(rst_i);
    endsequence
    property p_ack_once;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack not a single pulse after request");
    property p_amp;
        s_run |-> int'(tx_amplitude_mv_o) == AMP[tx_swing_code_o];
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplitude does not match swing code");
    property p_pd_off;
        s_pd_low |=> !tx_enable_o && !rx_enable_o;
    endproperty
    a_pd_off: assert property (p_pd_off)
        else $error("enable high while powered down");
    property p_eq_src;
        $rose(eq_hold_o) |-> $past(lt_eq_hold_i) || $past(wb_ack_o, 2);
    endproperty
    a_eq_src: assert property (p_eq_src)
        else $error("equalizer hold rose without a cause");
    property p_pll;
        s_run |-> int'(pll_mult_x4_o) == X4[pll_multiplier_sel_o]
            && pll_mult_valid_o == (X4[pll_multiplier_sel_o] != 0);
    endproperty
    a_pll: assert property (p_pll)
        else $error("multiplier decode wrong");
    property p_rx_rsv;
        s_run |-> rx_rate_reserved_o == !(rx_rate_sel_o inside {0, 5, 6, 7});
    endproperty
    a_rx_rsv: assert property (p_rx_rsv)
        else $error("receive rate reserved flag wrong");
    property p_order_rsv;
        s_run |-> cdr_order_reserved_o == (cdr_loop_order_sel_o == 2'h3);
    endproperty
    a_order_rsv: assert property (p_order_rsv)
        else $error("loop order reserved flag wrong");
    property p_crf_valid;
        s_run |-> cursor_reduction_valid_o
            == !(cursor_reduction_sel_o inside {[7:15]});
    endproperty
    a_crf_valid: assert property (p_crf_valid)
        else $error("cursor valid flag wrong");
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the serdes configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int AMP [16] = '{130, 220, 300, 390, 480, 570, 660, 750,
        830, 930, 1020, 1110, 1180, 1270, 1340, 1400};
    localparam int X4 [16] = '{0, 0, 16, 20, 24, 32, 33, 40, 48, 50, 60,
        64, 66, 80, 100, 0};
    localparam int CRF [32] = '{0, 25, 50, 75, 100, 120, 150, 0, 0, 0, 0,
        0, 0, 0, 0, 0, 170, 200, 220, 250, 270, 300, 320, 350, 370, 400,
        420, 450, 470, 500, 520, 550};
    localparam int RS [8] = '{0, 0, 0, 0, 0, 1, 2, 3};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic channel_powerdown_n_i = 1'b1, ref_frequency_select_one_i = 1'b0;
    logic lt_eq_hold_i = 1'b0, lt_adc_track_i = 1'b0, auto_rx_enable_i = 1'b1;
    logic [4:0] lt_cursor_reduction_i = 5'h00;
    logic [1:0] auto_tx_rate_i = 2'h0;
    logic [2:0] auto_rx_rate_i = 3'h0;
    logic [3:0] auto_pll_multiplier_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, tx_enable_o, rx_enable_o, eq_hold_o, rx_rate_reserved_o;
    logic pll_mult_valid_o, adc_track_force_o, rx_precursor_en_o;
    logic cdr_order_reserved_o, hf_peaking_off_o, short_channel_cdr_o;
    logic cursor_reduction_valid_o;
    logic [3:0] tx_swing_code_o, pll_multiplier_sel_o, rx_precursor_ninths_o;
    logic [10:0] tx_amplitude_mv_o;
    logic [1:0] tx_rate_sel_o, rx_rate_shift_o, cdr_loop_order_sel_o;
    logic [2:0] rx_rate_sel_o;
    logic [6:0] pll_mult_x4_o;
    logic [5:0] cdr_vote_count_o;
    logic [4:0] cursor_reduction_sel_o;
    logic [9:0] cursor_reduction_tenths_o;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    hs_serdes_config_regs hs_serdes_config_regs_inst (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .channel_powerdown_n_i,
        .ref_frequency_select_one_i, .lt_eq_hold_i, .lt_adc_track_i,
        .lt_cursor_reduction_i, .auto_tx_rate_i, .auto_rx_rate_i,
        .auto_pll_multiplier_i, .auto_rx_enable_i, .tx_swing_code_o,
        .tx_amplitude_mv_o, .tx_enable_o, .rx_enable_o, .eq_hold_o,
        .tx_rate_sel_o, .rx_rate_sel_o, .rx_rate_shift_o, .rx_rate_reserved_o,
        .pll_multiplier_sel_o, .pll_mult_x4_o, .pll_mult_valid_o,
        .adc_track_force_o, .rx_precursor_en_o, .rx_precursor_ninths_o,
        .cdr_loop_order_sel_o, .cdr_order_reserved_o, .cdr_vote_count_o,
        .hf_peaking_off_o, .short_channel_cdr_o, .cursor_reduction_sel_o,
        .cursor_reduction_tenths_o, .cursor_reduction_valid_o);
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic finish_test();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Whole run is well under two thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp,
            input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic we, input logic [7:0] adr,
            input logic [15:0] wd, input logic [3:0] sel,
            output logic [15:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
        logic [15:0] rd;
        xfer(1'b1, adr, wd, 4'h3, rd);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] adr,
            input logic [15:0] exp);
        logic [15:0] rd;
        xfer(1'b0, adr, 16'h0000, 4'hf, rd);
        chk(name, exp, rd);
    endtask
    // Covers the two-flop pin sync plus the output register
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        rd_chk("reg1", 8'h08, 16'h811d);
        rd_chk("reg2", 8'h0c, 16'h8848);
        rd_chk("reg3", 8'h10, 16'h1800);
        rd_chk("unmapped", 8'h80, 16'h0000);
        chk("swing", 16'h0008, 16'(tx_swing_code_o));
        chk("tx_en", 16'h0001, 16'(tx_enable_o));
        chk("pre_ninths", 16'h0003, 16'(rx_precursor_ninths_o));
        chk("order_rst", 16'h0002, 16'(cdr_loop_order_sel_o));
        chk("vote_rst", 16'h0004, 16'(cdr_vote_count_o));
        rd_chk("status", 8'h44, 16'h0083);
        for (int i = 0; i < 16; i++) begin
            wr(8'h0c, {4'(i), 12'h848});
            settle();
            chk("amplitude", 16'(AMP[i]), 16'(tx_amplitude_mv_o));
        end
        wr(8'h0c, 16'h8c48);
        settle();
        chk("eq_ignored", 16'h0000, 16'(eq_hold_o));
        rd_chk("reg2_back", 8'h0c, 16'h8c48);
        wr(8'h40, 16'h0001);
        settle();
        chk("eq_ovr", 16'h0001, 16'(eq_hold_o));
        wr(8'h40, 16'h0020);
        settle();
        chk("tx_gpd", 16'h0000, 16'(tx_enable_o));
        chk("rx_gpd", 16'h0000, 16'(rx_enable_o));
        auto_rx_enable_i <= 1'b0;
        lt_eq_hold_i <= 1'b1;
        wr(8'h40, 16'h0010);
        settle();
        chk("rx_ovr", 16'h0001, 16'(rx_enable_o));
        chk("eq_lt", 16'h0001, 16'(eq_hold_o));
        channel_powerdown_n_i <= 1'b0;
        settle();
        chk("tx_pd", 16'h0000, 16'(tx_enable_o));
        chk("rx_pd", 16'h0000, 16'(rx_enable_o));
        channel_powerdown_n_i <= 1'b1;
        auto_tx_rate_i <= 2'h3;
        wr(8'h40, 16'h0000);
        settle();
        chk("tx_rate_auto", 16'h0003, 16'(tx_rate_sel_o));
        ref_frequency_select_one_i <= 1'b1;
        wr(8'h0c, 16'h8a4d);
        settle();
        chk("tx_rate_reg", 16'h0002, 16'(tx_rate_sel_o));
        chk("rx_rate_reg", 16'h0005, 16'(rx_rate_sel_o));
        chk("pll_reg", 16'h0050, 16'(pll_mult_x4_o));
        ref_frequency_select_one_i <= 1'b0;
        settle();
        for (int i = 0; i < 16; i++) begin
            auto_pll_multiplier_i <= 4'(i);
            repeat (2) @(posedge clk_i);
            chk("pll_x4", 16'(X4[i]), 16'(pll_mult_x4_o));
        end
        for (int i = 0; i < 8; i++) begin
            auto_rx_rate_i <= 3'(i);
            repeat (2) @(posedge clk_i);
            chk("rx_shift", 16'(RS[i]), 16'(rx_rate_shift_o));
        end
        wr(8'h40, 16'h0008);
        settle();
        chk("rate_ovr", 16'h0002, 16'(tx_rate_sel_o));
        chk("pll_ovr", 16'h000d, 16'(pll_multiplier_sel_o));
        for (int i = 0; i < 32; i++) begin
            lt_cursor_reduction_i <= 5'(i);
            repeat (2) @(posedge clk_i);
            chk("crf", 16'(CRF[i]),
                16'(cursor_reduction_tenths_o));
        end
        wr(8'h10, 16'hff73);
        wr(8'h40, 16'h0006);
        settle();
        chk("track", 16'h0001, 16'(adc_track_force_o));
        chk("pre_en", 16'h0000, 16'(rx_precursor_en_o));
        chk("order", 16'h0001, 16'(cdr_order_reserved_o));
        chk("vote", 16'h0020, 16'(cdr_vote_count_o));
        chk("peak", 16'h0001, 16'(hf_peaking_off_o));
        chk("short", 16'h0001, 16'(short_channel_cdr_o));
        chk("crf_sel", 16'h0013, 16'(cursor_reduction_sel_o));
        rd_chk("reg3_back", 8'h10, 16'hff73);
        finish_test();
    end
endmodule
bind hs_serdes_config_regs hs_serdes_config_sva hs_serdes_config_sva_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .channel_powerdown_n_i,
    .lt_eq_hold_i, .tx_enable_o, .rx_enable_o, .eq_hold_o, .tx_swing_code_o,
    .tx_amplitude_mv_o, .pll_multiplier_sel_o, .pll_mult_x4_o,
    .pll_mult_valid_o, .rx_rate_sel_o, .rx_rate_reserved_o,
    .cdr_loop_order_sel_o, .cdr_order_reserved_o, .cursor_reduction_sel_o,
    .cursor_reduction_valid_o);
`default_nettype wire
